// ### rtl/bfsc_defines.svh
// constants of the booster feedback and current sink control block
// assumes a 100 MHz system clock and a 32-bit AXI4-Lite register port
//
// Operation
// - boosters one and three use fixed feedback pins
// - feedback select picks a sink for booster two
// - protect pin select picks overvoltage pin, 1.25V clamp
// - booster two overvoltage protection only when disable=0
// - all used sinks at 10b selects highest string
// - feedback select 00b regulates chosen pin voltage
// - five-bit tuning current 0 to 31 uA
// - load detect after 1ms sense or non-skip
// - overcurrent flag after 5ms continuous overcurrent
// - overcurrent flag cleared only by enable 0-1
// - overcurrent plus disconnect enable opens load switch
// - switching clock is system clock divided by four
// - six-bit sink code sets current linearly
// - code 00h with booster two on: protection current
// - sink three may be open-drain status output
// - sinks have independent enable and current settings
`ifndef BFSC_DEFINES_SVH
`define BFSC_DEFINES_SVH

// --------------------
// register byte addresses
// --------------------
`define BFSC_ADDR_B2_CTRL 8'h00
`define BFSC_ADDR_TUNE1 8'h04
`define BFSC_ADDR_TUNE2 8'h08
`define BFSC_ADDR_TUNE3 8'h0C
`define BFSC_ADDR_PROT 8'h10
`define BFSC_ADDR_STATUS 8'h14
`define BFSC_ADDR_SINK1 8'h18
`define BFSC_ADDR_SINK2 8'h1C
`define BFSC_ADDR_SINK3 8'h20

// --------------------
// field positions
// --------------------
`define BFSC_B2_FBSEL_LSB 0
`define BFSC_B2_PPIN_LSB 2
`define BFSC_B2_PDIS_BIT 4
`define BFSC_B2_EN_BIT 5
`define BFSC_TUNE_LSB 0
`define BFSC_TUNE_RES_BIT 5
`define BFSC_PROT_EN_BIT 0
`define BFSC_PROT_DISC_BIT 1
`define BFSC_ST_DET_BIT 0
`define BFSC_ST_OC_BIT 1
`define BFSC_ST_AUTO_BIT 2
`define BFSC_ST_FB_LSB 3
`define BFSC_SINK_CODE_LSB 0
`define BFSC_SINK_CTRL_LSB 6
`define BFSC_SINK_STSEL_LSB 8

// ----------------------------------------------------------------
// reset values
// ----------------------------------------------------------------
`define BFSC_B2_CTRL_RST 6'h00
`define BFSC_TUNE_RST 6'h00
`define BFSC_PROT_RST 2'h0
`define BFSC_SINK_RST 10'h000

// ----------------------------------------------------------------
// timing and bus answers
// ----------------------------------------------------------------
`define BFSC_CLK_MHZ 100
`define BFSC_DETECT_US 1000
`define BFSC_OC_US 5000
`define BFSC_SW_DIV 4
`define BFSC_RESP_OKAY 2'h0
`define BFSC_RESP_SLVERR 2'h2

`endif

// ### rtl/bfsc_pkg.sv
// types shared by the booster feedback and current sink control block
// assumes the register layout of bfsc_defines.svh
package bfsc_pkg;

   typedef enum logic [1:0] {
      BFSC_FB_VOLTAGE,
      BFSC_FB_SINK1,
      BFSC_FB_SINK2,
      BFSC_FB_SINK3
   } bfsc_fb_sel_t;

   typedef enum logic [1:0] {
      BFSC_SINK_OFF,
      BFSC_SINK_ON,
      BFSC_SINK_AUTO,
      BFSC_SINK_STATUS
   } bfsc_sink_ctrl_t;

   typedef enum logic [1:0] {
      BFSC_ST_LOW_BATT,
      BFSC_ST_POWER_GOOD,
      BFSC_ST_OVERCURRENT,
      BFSC_ST_LOAD_DETECT
   } bfsc_status_sel_t;

endpackage

// ### rtl/bfsc_deb_if.sv
// condition and result of one debounce timer
// assumes one clock domain shared by both ends
`timescale 1ns/1ps
interface bfsc_deb_if;
   logic cond;
   logic hit;
   modport src (output cond, input hit);
   modport dut (input cond, output hit);
endinterface

// ### rtl/bfsc_debounce.sv
// debounce timer: one-cycle hit after cond held CYCLES clocks
// assumes cond synchronous to i_clk
`timescale 1ns/1ps
module bfsc_debounce #(
   parameter int CYCLES = 100000,
   parameter int CNT_W = 20
) (
   input wire logic i_clk,
   input wire logic i_reset,
   bfsc_deb_if.dut deb
);
   logic [CNT_W-1:0] cnt_r;
   logic [CNT_W-1:0] cnt_nxt;
   logic hit_r;
   logic hit_nxt;

   // saturates so a held condition reports only once
   always_comb
   begin
      cnt_nxt = cnt_r;
      hit_nxt = 1'b0;
      if (!deb.cond)
         cnt_nxt = '0;
      else if (cnt_r != CNT_W'(CYCLES))
      begin
         cnt_nxt = cnt_r + 1'b1;
         hit_nxt = (cnt_r == CNT_W'(CYCLES - 1));
      end
   end

   always_ff @(posedge i_clk)
   begin
      if (i_reset)
      begin
         cnt_r <= '0;
         hit_r <= 1'b0;
      end
      else
      begin
         cnt_r <= cnt_nxt;
         hit_r <= hit_nxt;
      end
   end

   assign deb.hit = hit_r;
endmodule // bfsc_debounce

// ### rtl/bfsc_clkdiv.sv
// booster switching clock divider
// assumes i_clk is the internal converter clock
`timescale 1ns/1ps
module bfsc_clkdiv #(
   parameter int DIV = 4
) (
   input wire logic i_clk,
   input wire logic i_reset,
   output logic o_sw_clk
);
   localparam int CW = $clog2(DIV);
   logic [CW-1:0] cnt_r;
   logic [CW-1:0] cnt_nxt;
   logic sw_r;
   logic sw_nxt;

   always_comb
   begin
      cnt_nxt = (cnt_r == CW'(DIV - 1)) ? '0 : cnt_r + 1'b1;
      sw_nxt = (cnt_nxt >= CW'(DIV / 2));
   end

   always_ff @(posedge i_clk)
   begin
      if (i_reset)
      begin
         cnt_r <= '0;
         sw_r <= 1'b0;
      end
      else
      begin
         cnt_r <= cnt_nxt;
         sw_r <= sw_nxt;
      end
   end

   assign o_sw_clk = sw_r;
endmodule // bfsc_clkdiv

// ### rtl/bfsc_top.sv
// booster feedback selection, booster one protection and sink control
// assumes AXI4-Lite master on i_clk; analog comparators already synchronous
//
// Added by the designer: the register addresses and the AXI4-Lite slave port.
`timescale 1ns/1ps
`include "bfsc_defines.svh"
module bfsc_top #(
   parameter int DETECT_CYCLES = `BFSC_DETECT_US * `BFSC_CLK_MHZ,
   parameter int OC_CYCLES = `BFSC_OC_US * `BFSC_CLK_MHZ,
   parameter int CNT_W = 20
) (
   input wire logic i_clk,
   input wire logic i_reset,
   input wire logic i_axi_awvalid,
   output logic o_axi_awready,
   input wire logic [7:0] i_axi_awaddr,
   input wire logic i_axi_wvalid,
   output logic o_axi_wready,
   input wire logic [31:0] i_axi_wdata,
   input wire logic [3:0] i_axi_wstrb,
   output logic o_axi_bvalid,
   input wire logic i_axi_bready,
   output logic [1:0] o_axi_bresp,
   input wire logic i_axi_arvalid,
   output logic o_axi_arready,
   input wire logic [7:0] i_axi_araddr,
   output logic o_axi_rvalid,
   input wire logic i_axi_rready,
   output logic [31:0] o_axi_rdata,
   output logic [1:0] o_axi_rresp,
   input wire logic i_sense_above_detect,
   input wire logic i_boost_one_not_skipping,
   input wire logic i_sense_above_overcurrent,
   input wire logic [1:0] i_highest_sink,
   input wire logic i_low_battery,
   input wire logic i_power_good,
   output logic o_sw_clk,
   output logic [1:0] o_boost_two_feedback_mode,
   output logic [1:0] o_boost_two_voltage_pin_select,
   output logic o_boost_two_protect_on,
   output logic o_boost_two_enable,
   output logic [14:0] o_feedback_tuning_current,
   output logic [2:0] o_two_resistor_divider_flag,
   output logic o_boost_one_protect_enable,
   output logic o_load_switch_on,
   output logic o_boost_one_load_event,
   output logic o_boost_one_overcurrent_event,
   output logic [17:0] o_sink_code,
   output logic [2:0] o_sink_on,
   output logic [2:0] o_sink_protect_current,
   output logic o_sink_three_od_out,
   output logic o_sink_three_od_oe
);

   // --------------------
   // register state
   // --------------------
   logic [5:0] b2_ctrl_r;
   logic [5:0] b2_ctrl_nxt;
   logic [5:0] tune_r [3];
   logic [5:0] tune_nxt [3];
   logic [1:0] prot_r;
   logic [1:0] prot_nxt;
   logic [9:0] sink_r [3];
   logic [9:0] sink_nxt [3];
   logic det_r;
   logic det_nxt;
   logic oc_r;
   logic oc_nxt;
   logic prot_en_d_r;
   logic od_oe_r;
   logic od_oe_nxt;

   // --------------------
   // bus state
   // --------------------
   logic aw_hold_r;
   logic aw_hold_nxt;
   logic [7:0] awaddr_r;
   logic [7:0] awaddr_nxt;
   logic w_hold_r;
   logic w_hold_nxt;
   logic [31:0] wdata_r;
   logic [31:0] wdata_nxt;
   logic [3:0] wstrb_r;
   logic [3:0] wstrb_nxt;
   logic bvalid_r;
   logic bvalid_nxt;
   logic [1:0] bresp_r;
   logic [1:0] bresp_nxt;
   logic rvalid_r;
   logic rvalid_nxt;
   logic [31:0] rdata_r;
   logic [31:0] rdata_nxt;
   logic [1:0] rresp_r;
   logic [1:0] rresp_nxt;

   // --------------------
   // derived control
   // --------------------
   logic do_write;
   logic wr_hit;
   logic [31:0] wmask;
   logic [31:0] status_word;
   logic [2:0] sink_used;
   logic [2:0] sink_auto;
   logic auto_mode;
   logic [1:0] eff_fb;
   logic status_val;
   logic prot_en;
   logic disc_en;
   logic det_hit;
   logic oc_hit;
   bfsc_pkg::bfsc_sink_ctrl_t sink_ctrl [3];

   bfsc_deb_if det_if ();
   bfsc_deb_if oc_if ();

   assign prot_en = prot_r[`BFSC_PROT_EN_BIT];
   assign disc_en = prot_r[`BFSC_PROT_DISC_BIT];

   // --------------------
   // booster one load detection and overcurrent timers
   // --------------------
   assign det_if.cond = i_sense_above_detect | i_boost_one_not_skipping;
   // protection off keeps the timer at zero, so the flag cannot rearm
   assign oc_if.cond = i_sense_above_overcurrent & prot_en;
   assign det_hit = det_if.hit;
   assign oc_hit = oc_if.hit;

   bfsc_debounce #(
      .CYCLES(DETECT_CYCLES),
      .CNT_W(CNT_W)
   ) u_det_deb (
      .i_clk(i_clk),
      .i_reset(i_reset),
      .deb(det_if.dut)
   );

   bfsc_debounce #(
      .CYCLES(OC_CYCLES),
      .CNT_W(CNT_W)
   ) u_oc_deb (
      .i_clk(i_clk),
      .i_reset(i_reset),
      .deb(oc_if.dut)
   );

   bfsc_clkdiv #(
      .DIV(`BFSC_SW_DIV)
   ) u_clkdiv (
      .i_clk(i_clk),
      .i_reset(i_reset),
      .o_sw_clk(o_sw_clk)
   );

   // --------------------
   // per-sink decode
   // --------------------
   genvar gi;
   generate
      for (gi = 0; gi < 3; gi++)
      begin : g_sink
         assign sink_ctrl[gi] = bfsc_pkg::bfsc_sink_ctrl_t'(
            sink_r[gi][`BFSC_SINK_CTRL_LSB +: 2]);
         // each sink decodes its own register, plus the booster two enable bit for protection current
         assign sink_used[gi] = (sink_ctrl[gi] == bfsc_pkg::BFSC_SINK_ON)
            || (sink_ctrl[gi] == bfsc_pkg::BFSC_SINK_AUTO);
         assign sink_auto[gi] = (sink_ctrl[gi] == bfsc_pkg::BFSC_SINK_AUTO);
         assign o_sink_on[gi] = sink_used[gi];
         assign o_sink_code[gi*6 +: 6] = sink_r[gi][`BFSC_SINK_CODE_LSB +: 6];
         assign o_sink_protect_current[gi] = b2_ctrl_r[`BFSC_B2_EN_BIT]
            && (sink_r[gi][`BFSC_SINK_CODE_LSB +: 6] == 6'h00)
            && (sink_ctrl[gi] != bfsc_pkg::BFSC_SINK_STATUS);
         assign o_feedback_tuning_current[gi*5 +: 5] =
            tune_r[gi][`BFSC_TUNE_LSB +: 5];
         assign o_two_resistor_divider_flag[gi] = tune_r[gi][`BFSC_TUNE_RES_BIT];
      end
   endgenerate

   // --------------------
   // booster two feedback selection
   // --------------------
   // one unused sink does not block auto mode; an unassigned one would
   always_comb
   begin
      auto_mode = (|sink_used) && ((sink_used & ~sink_auto) == 3'h0);
      if (auto_mode)
         eff_fb = i_highest_sink;
      else
         eff_fb = b2_ctrl_r[`BFSC_B2_FBSEL_LSB +: 2];
   end

   assign o_boost_two_feedback_mode = eff_fb;
   assign o_boost_two_voltage_pin_select = b2_ctrl_r[`BFSC_B2_PPIN_LSB +: 2];
   assign o_boost_two_protect_on = !b2_ctrl_r[`BFSC_B2_PDIS_BIT];
   assign o_boost_two_enable = b2_ctrl_r[`BFSC_B2_EN_BIT];
   // boosters one and three carry no selector: only tuning, plus booster one protection, reaches them
   assign o_boost_one_protect_enable = prot_en;
   assign o_load_switch_on = !(oc_r && disc_en);
   assign o_boost_one_load_event = det_hit;
   assign o_boost_one_overcurrent_event = oc_hit;

   // --------------------
   // sink three status output
   // --------------------
   always_comb
   begin
      unique case (bfsc_pkg::bfsc_status_sel_t'(sink_r[2][`BFSC_SINK_STSEL_LSB +: 2]))
         bfsc_pkg::BFSC_ST_LOW_BATT: status_val = i_low_battery;
         bfsc_pkg::BFSC_ST_POWER_GOOD: status_val = i_power_good;
         bfsc_pkg::BFSC_ST_OVERCURRENT: status_val = oc_r;
         bfsc_pkg::BFSC_ST_LOAD_DETECT: status_val = det_r;
      endcase
      // open drain: pull low while the status is inactive
      od_oe_nxt = (sink_ctrl[2] == bfsc_pkg::BFSC_SINK_STATUS) && !status_val;
   end

   assign o_sink_three_od_out = 1'b0;
   assign o_sink_three_od_oe = od_oe_r;

   // --------------------
   // AXI4-Lite write channel
   // --------------------
   assign o_axi_awready = !aw_hold_r;
   assign o_axi_wready = !w_hold_r;
   assign do_write = aw_hold_r && w_hold_r && !bvalid_r;

   always_comb
   begin
      for (int b = 0; b < 4; b++)
         wmask[b*8 +: 8] = {8{wstrb_r[b]}};
   end

   always_comb
   begin
      aw_hold_nxt = aw_hold_r;
      awaddr_nxt = awaddr_r;
      w_hold_nxt = w_hold_r;
      wdata_nxt = wdata_r;
      wstrb_nxt = wstrb_r;
      bvalid_nxt = bvalid_r;
      bresp_nxt = bresp_r;
      wr_hit = 1'b1;
      if (i_axi_awvalid && !aw_hold_r)
      begin
         aw_hold_nxt = 1'b1;
         awaddr_nxt = i_axi_awaddr;
      end
      if (i_axi_wvalid && !w_hold_r)
      begin
         w_hold_nxt = 1'b1;
         wdata_nxt = i_axi_wdata;
         wstrb_nxt = i_axi_wstrb;
      end
      if (bvalid_r && i_axi_bready)
         bvalid_nxt = 1'b0;
      if (do_write)
      begin
         unique case (awaddr_r)
            `BFSC_ADDR_B2_CTRL, `BFSC_ADDR_TUNE1, `BFSC_ADDR_TUNE2,
            `BFSC_ADDR_TUNE3, `BFSC_ADDR_PROT, `BFSC_ADDR_STATUS,
            `BFSC_ADDR_SINK1, `BFSC_ADDR_SINK2, `BFSC_ADDR_SINK3: wr_hit = 1'b1;
            default: wr_hit = 1'b0;
         endcase
         aw_hold_nxt = 1'b0;
         w_hold_nxt = 1'b0;
         bvalid_nxt = 1'b1;
         bresp_nxt = wr_hit ? `BFSC_RESP_OKAY : `BFSC_RESP_SLVERR;
      end
   end

   // --------------------
   // register updates
   // --------------------
   always_comb
   begin
      b2_ctrl_nxt = b2_ctrl_r;
      prot_nxt = prot_r;
      for (int i = 0; i < 3; i++)
      begin
         tune_nxt[i] = tune_r[i];
         sink_nxt[i] = sink_r[i];
      end
      det_nxt = det_r;
      oc_nxt = oc_r;
      if (do_write)
      begin
         unique case (awaddr_r)
            `BFSC_ADDR_B2_CTRL:
               b2_ctrl_nxt = 6'((b2_ctrl_r & ~wmask[5:0]) | (wdata_r[5:0] & wmask[5:0]));
            `BFSC_ADDR_TUNE1:
               tune_nxt[0] = 6'((tune_r[0] & ~wmask[5:0]) | (wdata_r[5:0] & wmask[5:0]));
            `BFSC_ADDR_TUNE2:
               tune_nxt[1] = 6'((tune_r[1] & ~wmask[5:0]) | (wdata_r[5:0] & wmask[5:0]));
            `BFSC_ADDR_TUNE3:
               tune_nxt[2] = 6'((tune_r[2] & ~wmask[5:0]) | (wdata_r[5:0] & wmask[5:0]));
            `BFSC_ADDR_PROT:
               prot_nxt = 2'((prot_r & ~wmask[1:0]) | (wdata_r[1:0] & wmask[1:0]));
            `BFSC_ADDR_STATUS:
               if (wmask[`BFSC_ST_DET_BIT] && wdata_r[`BFSC_ST_DET_BIT])
                  det_nxt = 1'b0;
            `BFSC_ADDR_SINK1:
               sink_nxt[0] = 10'((sink_r[0] & ~wmask[9:0]) | (wdata_r[9:0] & wmask[9:0]));
            `BFSC_ADDR_SINK2:
               sink_nxt[1] = 10'((sink_r[1] & ~wmask[9:0]) | (wdata_r[9:0] & wmask[9:0]));
            `BFSC_ADDR_SINK3:
               sink_nxt[2] = 10'((sink_r[2] & ~wmask[9:0]) | (wdata_r[9:0] & wmask[9:0]));
            default:
               det_nxt = det_r;
         endcase
      end
      // the flag clears on the off-to-on edge of protect enable
      if (prot_en && !prot_en_d_r)
         oc_nxt = 1'b0;
      // a new event wins over a clear in the same cycle
      if (det_hit)
         det_nxt = 1'b1;
      if (oc_hit)
         oc_nxt = 1'b1;
   end

   // --------------------
   // AXI4-Lite read channel
   // --------------------
   assign o_axi_arready = !rvalid_r;

   always_comb
   begin
      status_word = 32'h0000_0000;
      status_word[`BFSC_ST_DET_BIT] = det_r;
      status_word[`BFSC_ST_OC_BIT] = oc_r;
      status_word[`BFSC_ST_AUTO_BIT] = auto_mode;
      status_word[`BFSC_ST_FB_LSB +: 2] = eff_fb;
   end

   always_comb
   begin
      rvalid_nxt = rvalid_r;
      rdata_nxt = rdata_r;
      rresp_nxt = rresp_r;
      if (rvalid_r && i_axi_rready)
         rvalid_nxt = 1'b0;
      if (i_axi_arvalid && !rvalid_r)
      begin
         rvalid_nxt = 1'b1;
         rresp_nxt = `BFSC_RESP_OKAY;
         unique case (i_axi_araddr)
            `BFSC_ADDR_B2_CTRL: rdata_nxt = {26'h0, b2_ctrl_r};
            `BFSC_ADDR_TUNE1: rdata_nxt = {26'h0, tune_r[0]};
            `BFSC_ADDR_TUNE2: rdata_nxt = {26'h0, tune_r[1]};
            `BFSC_ADDR_TUNE3: rdata_nxt = {26'h0, tune_r[2]};
            `BFSC_ADDR_PROT: rdata_nxt = {30'h0, prot_r};
            `BFSC_ADDR_STATUS: rdata_nxt = status_word;
            `BFSC_ADDR_SINK1: rdata_nxt = {22'h0, sink_r[0]};
            `BFSC_ADDR_SINK2: rdata_nxt = {22'h0, sink_r[1]};
            `BFSC_ADDR_SINK3: rdata_nxt = {22'h0, sink_r[2]};
            default:
            begin
               rdata_nxt = 32'h0000_0000;
               rresp_nxt = `BFSC_RESP_SLVERR;
            end
         endcase
      end
   end

   assign o_axi_bvalid = bvalid_r;
   assign o_axi_bresp = bresp_r;
   assign o_axi_rvalid = rvalid_r;
   assign o_axi_rdata = rdata_r;
   assign o_axi_rresp = rresp_r;

   // --------------------
   // state registers
   // --------------------
   always_ff @(posedge i_clk)
   begin
      if (i_reset)
      begin
         b2_ctrl_r <= `BFSC_B2_CTRL_RST;
         prot_r <= `BFSC_PROT_RST;
         for (int i = 0; i < 3; i++)
         begin
            tune_r[i] <= `BFSC_TUNE_RST;
            sink_r[i] <= `BFSC_SINK_RST;
         end
         det_r <= 1'b0;
         oc_r <= 1'b0;
         prot_en_d_r <= 1'b0;
         od_oe_r <= 1'b0;
         aw_hold_r <= 1'b0;
         awaddr_r <= 8'h00;
         w_hold_r <= 1'b0;
         wdata_r <= 32'h0000_0000;
         wstrb_r <= 4'h0;
         bvalid_r <= 1'b0;
         bresp_r <= `BFSC_RESP_OKAY;
         rvalid_r <= 1'b0;
         rdata_r <= 32'h0000_0000;
         rresp_r <= `BFSC_RESP_OKAY;
      end
      else
      begin
         b2_ctrl_r <= b2_ctrl_nxt;
         prot_r <= prot_nxt;
         for (int i = 0; i < 3; i++)
         begin
            tune_r[i] <= tune_nxt[i];
            sink_r[i] <= sink_nxt[i];
         end
         det_r <= det_nxt;
         oc_r <= oc_nxt;
         prot_en_d_r <= prot_en;
         od_oe_r <= od_oe_nxt;
         aw_hold_r <= aw_hold_nxt;
         awaddr_r <= awaddr_nxt;
         w_hold_r <= w_hold_nxt;
         wdata_r <= wdata_nxt;
         wstrb_r <= wstrb_nxt;
         bvalid_r <= bvalid_nxt;
         bresp_r <= bresp_nxt;
         rvalid_r <= rvalid_nxt;
         rdata_r <= rdata_nxt;
         rresp_r <= rresp_nxt;
      end
   end

endmodule // bfsc_top

// ### dv/bfsc_load_model.sv
// far side of booster one: sense resistor and switching stage as comparators
// assumes the bench gives the load current in mA
`timescale 1ns/1ps
module bfsc_load_model #(
   parameter int DET_MA = 83,
   parameter int SKIP_MA = 300,
   parameter int OC_MA = 1200
) (
   input wire logic [15:0] i_load_ma,
   output logic o_above_detect,
   output logic o_not_skipping,
   output logic o_above_oc
);
   // comparators only, no hysteresis: the bench never loiters at a threshold
   assign o_above_detect = i_load_ma > DET_MA;
   assign o_not_skipping = i_load_ma > SKIP_MA;
   assign o_above_oc = i_load_ma > OC_MA;
endmodule // bfsc_load_model

// ### dv/bfsc_top_asserts.sv
// checker of bfsc_top port timing
// assumes bind from the bench, one clock, synchronous reset
`timescale 1ns/1ps
module bfsc_top_asserts #(
   parameter int DETECT_CYCLES = 20,
   parameter int OC_CYCLES = 50
) (
   input wire logic i_clk,
   input wire logic i_reset,
   input wire logic i_sense_above_detect,
   input wire logic i_boost_one_not_skipping,
   input wire logic i_sense_above_overcurrent,
   input wire logic o_sw_clk,
   input wire logic o_boost_two_enable,
   input wire logic o_boost_one_protect_enable,
   input wire logic o_boost_one_load_event,
   input wire logic o_boost_one_overcurrent_event,
   input wire logic [17:0] o_sink_code,
   input wire logic [2:0] o_sink_on,
   input wire logic [2:0] o_sink_protect_current,
   input wire logic o_sink_three_od_out,
   input wire logic o_sink_three_od_oe
);
   default clocking @(posedge i_clk); endclocking
   default disable iff (i_reset);
   int det_n_r, det_n_nxt, oc_n_r, oc_n_nxt;
   logic [2:0] zero;
   logic on3;
   assign on3 = o_sink_on[2];
   assign zero = {o_sink_code[17:12] == 6'h00, o_sink_code[11:6] == 6'h00,
                  o_sink_code[5:0] == 6'h00};
   // run lengths of unbroken conditions
   always_comb
   begin
      det_n_nxt = (i_sense_above_detect | i_boost_one_not_skipping) ? det_n_r + 1 : 0;
      oc_n_nxt = (i_sense_above_overcurrent & o_boost_one_protect_enable) ? oc_n_r + 1 : 0;
   end
   always_ff @(posedge i_clk)
   begin
      det_n_r <= i_reset ? 0 : det_n_nxt;
      oc_n_r <= i_reset ? 0 : oc_n_nxt;
   end
   sequence sw_period;
      o_sw_clk ##1 !o_sw_clk [*2] ##1 o_sw_clk;
   endsequence
   sw_clk_a: assert property ($rose(o_sw_clk) |=> sw_period)
      else $error("sw clk period");
   det_fire_a: assert property (det_n_r == DETECT_CYCLES |-> ##[0:1] o_boost_one_load_event)
      else $error("detect late");
   det_wait_a: assert property (o_boost_one_load_event |-> det_n_r >= DETECT_CYCLES)
      else $error("detect early");
   det_pulse_a: assert property (o_boost_one_load_event |=> !o_boost_one_load_event)
      else $error("detect pulse");
   oc_fire_a: assert property (oc_n_r == OC_CYCLES |-> ##[0:1] o_boost_one_overcurrent_event)
      else $error("oc late");
   oc_wait_a: assert property (o_boost_one_overcurrent_event |-> oc_n_r >= OC_CYCLES)
      else $error("oc early");
   oc_once_a: assert property (oc_n_r > OC_CYCLES + 1 |-> !o_boost_one_overcurrent_event)
      else $error("oc twice");
   prot_need_a: assert property (o_sink_protect_current != 3'h0 |->
      o_boost_two_enable && (o_sink_protect_current & ~zero) == 3'h0) else $error("prot cur");
   prot_give_a: assert property (o_boost_two_enable |->
      (zero & o_sink_on & ~o_sink_protect_current) == 3'h0) else $error("no prot cur");
   od_pin_a: assert property (o_sink_three_od_oe |-> !o_sink_three_od_out && !$past(on3))
      else $error("od pin");
endmodule // bfsc_top_asserts

// ### dv/bfsc_top_tb.sv
// self-checking bench of bfsc_top
// assumes bfsc_load_model as far side and the checker bound below
`timescale 1ns/1ps
module bfsc_top_tb;
   typedef struct {logic [7:0] a; logic [31:0] d; logic [31:0] e; logic [1:0] r;} bfsc_row_t;
   logic i_clk = 1'h0, i_reset = 1'h1, i_low_battery = 1'h0, i_power_good = 1'h0;
   logic i_axi_awvalid = 1'h0, i_axi_wvalid = 1'h0, i_axi_bready = 1'h0;
   logic i_axi_arvalid = 1'h0, i_axi_rready = 1'h0;
   logic [7:0] i_axi_awaddr = '0, i_axi_araddr = '0;
   logic [31:0] i_axi_wdata = '0, o_axi_rdata, rd;
   logic [3:0] i_axi_wstrb = 4'hF;
   logic [1:0] i_highest_sink = 2'h1, o_axi_bresp, o_axi_rresp, rsp;
   logic [1:0] o_boost_two_feedback_mode, o_boost_two_voltage_pin_select;
   logic i_sense_above_detect, i_boost_one_not_skipping, i_sense_above_overcurrent;
   logic o_axi_awready, o_axi_wready, o_axi_bvalid, o_axi_arready, o_axi_rvalid, o_sw_clk;
   logic o_boost_two_protect_on, o_boost_two_enable, o_boost_one_protect_enable;
   logic o_load_switch_on, o_boost_one_load_event, o_boost_one_overcurrent_event;
   logic [14:0] o_feedback_tuning_current;
   logic [2:0] o_two_resistor_divider_flag, o_sink_on, o_sink_protect_current;
   logic [17:0] o_sink_code;
   logic o_sink_three_od_out, o_sink_three_od_oe;
   logic [15:0] load_ma = '0;
   int n_mismatch = 0, checked = 0, n_det = 0, n_oc = 0;
   bfsc_row_t rows [8] = '{'{8'h04, 32'hFFFFFFE0, 32'h20, 2'h0},
      '{8'h08, 32'h1F, 32'h1F, 2'h0}, '{8'h0C, 32'h25, 32'h25, 2'h0},
      '{8'h18, 32'h3F, 32'h3F, 2'h0}, '{8'h1C, 32'h40, 32'h40, 2'h0},
      '{8'h20, 32'hAA, 32'hAA, 2'h0}, '{8'h10, 32'h3, 32'h3, 2'h0},
      '{8'h24, 32'h1, 32'h0, 2'h2}};
   bfsc_top #(.DETECT_CYCLES(20), .OC_CYCLES(50)) u_bfsc_top (.*);
   bfsc_load_model u_bfsc_load_model (.i_load_ma(load_ma), .o_above_detect(i_sense_above_detect),
      .o_not_skipping(i_boost_one_not_skipping), .o_above_oc(i_sense_above_overcurrent));
   always #5 i_clk = ~i_clk;
   always @(posedge i_clk)
   begin
      n_det <= n_det + (o_boost_one_load_event === 1'h1);
      n_oc <= n_oc + (o_boost_one_overcurrent_event === 1'h1);
   end
   task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
      checked++;
      if (seen !== exp)
      begin
         n_mismatch++;
         $display("Error at %0t seen %h expected %h", $time, seen, exp);
      end
   endtask
   task automatic wr(input logic [7:0] a, input logic [31:0] d);
      @(posedge i_clk);
      i_axi_awaddr <= a;
      i_axi_wdata <= d;
      i_axi_awvalid <= 1'h1;
      i_axi_wvalid <= 1'h1;
      i_axi_bready <= 1'h1;
      do
      begin
         @(posedge i_clk);
         if (o_axi_awready) i_axi_awvalid <= 1'h0;
         if (o_axi_wready) i_axi_wvalid <= 1'h0;
      end
      while (o_axi_bvalid !== 1'h1);
      rsp = o_axi_bresp;
      i_axi_bready <= 1'h0;
   endtask
   task automatic rdt(input logic [7:0] a);
      @(posedge i_clk);
      i_axi_araddr <= a;
      i_axi_arvalid <= 1'h1;
      i_axi_rready <= 1'h1;
      do
      begin
         @(posedge i_clk);
         if (o_axi_arready) i_axi_arvalid <= 1'h0;
      end
      while (o_axi_rvalid !== 1'h1);
      rd = o_axi_rdata;
      rsp = o_axi_rresp;
      i_axi_rready <= 1'h0;
   endtask
   task automatic burst(input logic [15:0] ma, input int n);
      load_ma <= ma;
      repeat (15) @(posedge i_clk);
      load_ma <= '0;
      @(posedge i_clk);
      load_ma <= ma;
      repeat (n) @(posedge i_clk);
      load_ma <= '0;
   endtask
   task automatic print_verdict();
      $display("checks %0d mismatches %0d", checked, n_mismatch);
      if (n_mismatch == 0 && checked > 0)
         $display("bench passed");
      else
         $display("bench failed");
      $finish;
   endtask
   initial
   begin
      repeat (10) @(posedge i_clk);
      i_reset <= 1'h0;
      foreach (rows[i])
      begin
         wr(rows[i].a, rows[i].d);
         chk(rsp, rows[i].r);
         rdt(rows[i].a);
         chk(rd, rows[i].e);
         chk(rsp, rows[i].r);
      end
      chk(o_feedback_tuning_current, 15'h17E0);
      chk(o_two_resistor_divider_flag, 3'h5);
      chk(o_sink_code, 18'h2A03F);
      chk(o_sink_on, 3'h6);
      for (int s = 0; s < 4; s++)
      begin
         wr(8'h00, 32'h20 | s | (3 - s) << 2 | (s & 1) << 4);
         chk(o_boost_two_feedback_mode, s);
         chk(o_boost_two_voltage_pin_select, 3 - s);
         chk(o_boost_two_protect_on, ~s & 1);
      end
      chk(o_sink_protect_current, 3'h2);
      wr(8'h1C, 32'h80);
      for (int h = 3; h > 1; h--)
      begin
         i_highest_sink <= 2'(h);
         @(posedge i_clk);
         chk(o_boost_two_feedback_mode, h);
      end
      rdt(8'h14);
      chk(rd, 32'h14);
      wr(8'h18, 32'h7F);
      chk(o_boost_two_feedback_mode, 3);
      burst(16'h64, 25);
      chk(n_det, 1);
      rdt(8'h14);
      chk(rd, 32'h19);
      wr(8'h14, 32'h1);
      burst(16'h5DC, 60);
      chk(n_oc, 1);
      chk(o_load_switch_on, 0);
      wr(8'h10, 32'h3);
      rdt(8'h14);
      chk(rd, 32'h1B);
      wr(8'h10, 32'h1);
      chk(o_load_switch_on, 1);
      wr(8'h10, 32'h2);
      chk(o_load_switch_on, 0);
      wr(8'h10, 32'h3);
      rdt(8'h14);
      chk(rd, 32'h19);
      for (int k = 0; k < 4; k++)
      begin
         wr(8'h20, 32'hC0 | k << 8);
         {i_low_battery, i_power_good} <= 2'h0;
         repeat (2) @(posedge i_clk);
         chk(o_sink_three_od_oe, k != 3);
         {i_low_battery, i_power_good} <= 2'h3;
         repeat (2) @(posedge i_clk);
         chk(o_sink_three_od_oe, k == 2);
      end
      i_reset <= 1'h1;
      repeat (2) @(posedge i_clk);
      i_reset <= 1'h0;
      chk(o_load_switch_on, 1);
      foreach (rows[i])
      begin
         rdt(rows[i].a);
         chk(rd, 0);
      end
      print_verdict();
   end
   initial
   begin
      repeat (3000) @(posedge i_clk);
      n_mismatch++;
      print_verdict();
   end
endmodule // bfsc_top_tb
bind bfsc_top bfsc_top_asserts #(.DETECT_CYCLES(DETECT_CYCLES), .OC_CYCLES(OC_CYCLES))
   u_bfsc_top_asserts (.*);
